// [acr_analog_model.sv]
// analog sources and comparator standing in front of the converter
module acr_analog_model (
	input wire logic clk, // system clock
	input wire logic [3:0] analogChannelSelect, // mux select
	input wire logic channelValid, // selected input exists
	input wire logic [9:0] trialCode, // trial level
	output logic compIn // input at or above trial level
);
	logic [9:0] drift = 10'h155;
	// a missing input floats; here its level stays at 155h, since rotating and inverting 155h gives 155h again
	always @(posedge clk)
		drift <= ~{drift[8:0], drift[9]};
	assign compIn = (channelValid ? {analogChannelSelect, 6'h2d} : drift) >= trialCode;
endmodule

// [acr_checker.sv]
// port assertions for the converter control block
module acr_checker (
	input wire clk, // clock
	input wire rst_n, // reset
	input wire [2:0] regAddr, // index
	input wire [7:0] regWrData, // write data
	input wire regWr, // write strobe
	input wire regRd, // read strobe
	input wire [7:0] regRdData, // read data
	input wire [3:0] analogChannelSelect, // mux select
	input wire channelValid, // input exists
	input wire sampleEn, // sampling
	input wire [9:0] trialCode, // trial level
	input wire negReferenceSelect, // low reference
	input wire posReferenceSelect, // high reference
	input wire [12:0] analogPinMask, // analog pins
	input wire conversionDoneFlag // done
);
	reg onBit;
	// tells a conversion start apart from switching off
	always @(posedge clk) begin
		if (!rst_n)
			onBit <= 1'b0;
		else if (regWr && regAddr == 3'h0)
			onBit <= regWrData[0];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_allAnalog;
		(regWr && regAddr == 3'h1 && regWrData[3:0] <= 4'h2) ##1 !regWr;
	endsequence
	sequence s_start;
		$fell(sampleEn) && onBit;
	endsequence
	a_rd_top_zero: assert property ($past(regRd) && $past(regAddr) < 3'h2 |-> regRdData[7:6] == 2'h0)
		else $error("unimplemented bits read back set");
	a_pos_ref: assert property (regWr && regAddr == 3'h1 |-> ##2 posReferenceSelect == $past(regWrData[4], 2))
		else $error("high reference select wrong");
	a_neg_ref: assert property (regWr && regAddr == 3'h1 |-> ##2 negReferenceSelect == $past(regWrData[5], 2))
		else $error("low reference select wrong");
	a_all_analog: assert property (s_allAnalog |=> analogPinMask == 13'h1fff)
		else $error("pin mask not all analog");
	a_chan_follow: assert property (regWr && regAddr == 3'h0 |=> analogChannelSelect == $past(regWrData[5:2]))
		else $error("channel select not taken");
	a_no_chan: assert property ((analogChannelSelect > 4'hc) [*2] |-> !channelValid)
		else $error("missing channel marked valid");
	a_trial_msb: assert property (s_start |-> trialCode == 10'h200)
		else $error("first trial not midscale");
	a_conv_min: assert property (s_start |-> ##1 (!sampleEn) [*8])
		else $error("conversion ended too early");
	a_done_samples: assert property ($rose(conversionDoneFlag) |-> sampleEn)
		else $error("no sampling after done");
	a_done_sticky: assert property (conversionDoneFlag && !(regWr && regAddr == 3'h5) |=> conversionDoneFlag)
		else $error("done flag lost");
	a_off_idle: assert property (regWr && regAddr == 3'h0 && !regWrData[0] |=> !sampleEn)
		else $error("sampling while off");
endmodule
bind adc_control_registers acr_checker acr_checker_inst (.clk, .rst_n, .regAddr, .regWrData, .regWr,
	.regRd, .regRdData, .analogChannelSelect, .channelValid, .sampleEn, .trialCode,
	.negReferenceSelect, .posReferenceSelect, .analogPinMask, .conversionDoneFlag);

// [adc_control_registers.v]
// converter control registers, timing sequencer and successive approximation logic
`include "adc_defs.vh"
module adc_control_registers (
	input wire clk, // 10 MHz system clock
	input wire rst_n, // synchronous reset, active low
	input wire [2:0] regAddr, // register index
	input wire [7:0] regWrData, // write data
	input wire regWr, // write strobe
	input wire regRd, // read strobe
	output reg [7:0] regRdData, // read data, cycle after strobe
	input wire compIn, // comparator: input at or above trial level
	input wire portAnalogDefaultFuse, // fuse strap, sampled at reset
	input wire smallPackage, // strap, high on small package
	output reg [3:0] analogChannelSelect, // analog mux select
	output reg channelValid, // selected input exists
	output reg sampleEn, // sampling switch closed
	output reg [9:0] trialCode, // trial level for the comparator
	output reg negReferenceSelect, // low reference from input 2
	output reg posReferenceSelect, // high reference from input 3
	output reg [12:0] analogPinMask, // 1 = pin is analog
	output reg conversionDoneFlag // sticky done flag
);

////////////////////////////////////////////////////////////////////////////////
// state
// rc wait stands for the instruction cycle hold-off of the rc clock
localparam ST_IDLE = 2'h0;
localparam ST_RCWAIT = 2'h1;
localparam ST_ACQ = 2'h2;
localparam ST_CONV = 2'h3;

reg [1:0] state;
reg [1:0] next_state;
reg converterOn;
reg goFlag;
reg [1:0] cfgRef;
reg [3:0] pinAnalogConfig;
reg resultJustify;
reg [2:0] acquisitionTimeSelect;
reg [2:0] conversionClockSelect;
reg [9:0] result;
reg [9:0] sar;
reg [6:0] divCount;
reg [4:0] tadCount;
reg fuseMeta;
reg fuseSync;
reg pkgMeta;
reg pkgSync;

////////////////////////////////////////////////////////////////////////////////
// clock source and acquisition tables
reg [6:0] tadDiv;
reg [4:0] acqTads;
wire useRc;

// codes 3 and 7 both pick the rc clock
assign useRc = (conversionClockSelect[1:0] == 2'h3);

always @* begin
	case (conversionClockSelect)
	3'h0: tadDiv = `ADC_DIV2;
	3'h1: tadDiv = `ADC_DIV8;
	3'h2: tadDiv = `ADC_DIV32;
	3'h4: tadDiv = `ADC_DIV4;
	3'h5: tadDiv = `ADC_DIV16;
	3'h6: tadDiv = `ADC_DIV64;
	default: tadDiv = `ADC_RC_CLKS;
	endcase
end

always @* begin
	case (acquisitionTimeSelect)
	3'h0: acqTads = `ADC_ACQ0;
	3'h1: acqTads = `ADC_ACQ1;
	3'h2: acqTads = `ADC_ACQ2;
	3'h3: acqTads = `ADC_ACQ3;
	3'h4: acqTads = `ADC_ACQ4;
	3'h5: acqTads = `ADC_ACQ5;
	3'h6: acqTads = `ADC_ACQ6;
	default: acqTads = `ADC_ACQ7;
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// synchronisers for pins from outside
// the comparator is not here: the analog model drives it straight from trialCode, without a flop
always @(posedge clk) begin
	fuseMeta <= portAnalogDefaultFuse;
	fuseSync <= fuseMeta;
	pkgMeta <= smallPackage;
	pkgSync <= pkgMeta;
end

////////////////////////////////////////////////////////////////////////////////
// bit period timer: one tick per bit period, restarted on every state change
wire tadTick;
wire stateChange;

assign stateChange = (next_state != state);
// >= so that a divider change in mid-conversion cannot make the counter wrap
assign tadTick = (divCount >= tadDiv - 7'h01);

always @(posedge clk) begin
	if (!rst_n || stateChange || state == ST_IDLE) begin
		divCount <= 7'h00;
	end else if (state == ST_RCWAIT) begin
		// the hold-off counts plain clocks, not bit periods
		divCount <= divCount + 7'h01;
	end else if (tadTick) begin
		divCount <= 7'h00;
	end else begin
		divCount <= divCount + 7'h01;
	end
end

////////////////////////////////////////////////////////////////////////////////
// sequencer
wire goWrite;
wire rcDone;
wire acqDone;
wire convDone;

assign goWrite = regWr && regAddr == `ADC_IDX_CTRL0 && regWrData[1] && regWrData[0];
assign rcDone = (divCount == `ADC_TCY_CLKS - 7'h01);
assign acqDone = tadTick && (tadCount == acqTads - 5'h01);
assign convDone = tadTick && (tadCount == {1'b0, `ADC_CONV_TADS} - 5'h01);

always @* begin
	next_state = state;
	case (state)
	ST_IDLE: begin
		if (goWrite && converterOn) begin
			if (useRc) begin
				next_state = ST_RCWAIT;
			end else if (acqTads != `ADC_ACQ0) begin
				next_state = ST_ACQ;
			end else begin
				next_state = ST_CONV;
			end
		end
	end
	ST_RCWAIT: begin
		if (rcDone) begin
			next_state = (acqTads != `ADC_ACQ0) ? ST_ACQ : ST_CONV;
		end
	end
	ST_ACQ: begin
		if (acqDone) begin
			next_state = ST_CONV;
		end
	end
	ST_CONV: begin
		if (convDone) begin
			next_state = ST_IDLE;
		end
	end
	default: next_state = ST_IDLE;
	endcase
	// clearing the on bit drops to idle without setting the done flag, unless the last bit period ends in the write's cycle or the next
	if (!converterOn) begin
		next_state = ST_IDLE;
	end
end

always @(posedge clk) begin
	if (!rst_n) begin
		state <= ST_IDLE;
	end else begin
		state <= next_state;
	end
end

// counts bit periods inside the current state
always @(posedge clk) begin
	if (!rst_n || stateChange) begin
		tadCount <= 5'h00;
	end else if (tadTick && state != ST_IDLE) begin
		tadCount <= tadCount + 5'h01;
	end
end

////////////////////////////////////////////////////////////////////////////////
// successive approximation: first tick settles, ticks 1..10 decide bits 9..0
wire [3:0] bitPos;
wire decide;
wire [9:0] sarKeep;

// the comparator follows trialCode without a clock and is read straight: a two-flop synchroniser
// would need three clocks per decision, more than a two-clock bit period
assign sarKeep = compIn ? trialCode : sar;
assign decide = (state == ST_CONV) && tadTick && tadCount != 5'h00
	&& tadCount <= {1'b0, `ADC_SAR_BITS};
assign bitPos = `ADC_SAR_BITS - tadCount[3:0];

always @(posedge clk) begin
	if (!rst_n) begin
		sar <= 10'h000;
		trialCode <= 10'h000;
	end else if (state != ST_CONV) begin
		sar <= 10'h000;
		trialCode <= `ADC_TRIAL_MID;
	end else if (decide) begin
		// keep the trial bit when the input sits at or above it
		sar <= sarKeep;
		trialCode <= sarKeep
			| ((bitPos != 4'h0) ? (10'h001 << (bitPos - 4'h1)) : 10'h000);
	end
end

// result keeps its contents across reset, as the device does
always @(posedge clk) begin
	if (state == ST_CONV && convDone) begin
		// bit 0 is decided on this same edge, so take it from sarKeep
		result <= sarKeep;
	end
end

////////////////////////////////////////////////////////////////////////////////
// registers
wire ctrlWr0;
wire ctrlWr1;
wire ctrlWr2;
wire statWr;
wire nextOn;

assign ctrlWr0 = regWr && regAddr == `ADC_IDX_CTRL0;
assign ctrlWr1 = regWr && regAddr == `ADC_IDX_CTRL1;
assign ctrlWr2 = regWr && regAddr == `ADC_IDX_CTRL2;
assign statWr = regWr && regAddr == `ADC_IDX_STAT;
// writes to the result halves are ignored; status bit 0 clears on a 0
// on bit as it will stand after this edge, so sampling follows a write at once
assign nextOn = ctrlWr0 ? regWrData[0] : converterOn;

always @(posedge clk) begin
	if (!rst_n) begin
		{analogChannelSelect, goFlag, converterOn} <= `ADC_RST_CTRL0;
		cfgRef <= 2'h0;
		pinAnalogConfig <= {1'b0, fuseSync ? `ADC_PCFG_FUSE1 : `ADC_PCFG_FUSE0};
		{resultJustify, acquisitionTimeSelect, conversionClockSelect} <= `ADC_RST_CTRL2;
	end else begin
		if (ctrlWr0) begin
			analogChannelSelect <= regWrData[5:2];
			converterOn <= regWrData[0];
		end
		if (ctrlWr1) begin
			cfgRef <= regWrData[5:4];
			pinAnalogConfig <= regWrData[3:0];
		end
		if (ctrlWr2) begin
			resultJustify <= regWrData[7];
			acquisitionTimeSelect <= regWrData[5:3];
			conversionClockSelect <= regWrData[2:0];
		end
		// go mirrors the sequencer: high from the start edge until the done edge
		if (next_state != ST_IDLE) begin
			goFlag <= 1'b1;
		end else begin
			goFlag <= 1'b0;
		end
	end
end

// done flag: hardware set wins over a software clear
always @(posedge clk) begin
	if (!rst_n) begin
		conversionDoneFlag <= 1'b0;
	end else if (state == ST_CONV && convDone) begin
		conversionDoneFlag <= 1'b1;
	end else if (statWr && !regWrData[0]) begin
		conversionDoneFlag <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// analog side controls
wire chanExists;
reg [12:0] next_mask;
reg [3:0] digCount;
integer i;

// missing inputs still convert; only channelValid tells them apart
assign chanExists = analogChannelSelect <= `ADC_CH_LAST
	&& !(pkgSync && analogChannelSelect >= `ADC_CH_SMALL_LO
	&& analogChannelSelect <= `ADC_CH_SMALL_HI);

always @* begin
	next_mask = 13'h0000;
	// codes up to 2 leave every input analog
	digCount = (pinAnalogConfig <= `ADC_PCFG_ALLA) ? 4'h0 : pinAnalogConfig - `ADC_PCFG_ALLA;
	if (pinAnalogConfig == 4'hf) begin
		digCount = 4'hd;
	end
	for (i = 0; i < `ADC_NUM_IN; i = i + 1) begin
		next_mask[i] = (i < `ADC_NUM_IN - digCount);
	end
end

always @(posedge clk) begin
	if (!rst_n) begin
		channelValid <= 1'b0;
		sampleEn <= 1'b0;
		negReferenceSelect <= 1'b0;
		posReferenceSelect <= 1'b0;
		analogPinMask <= 13'h0000;
	end else begin
		channelValid <= chanExists;
		sampleEn <= nextOn && next_state != ST_CONV;
		negReferenceSelect <= cfgRef[1];
		posReferenceSelect <= cfgRef[0];
		analogPinMask <= next_mask;
	end
end

////////////////////////////////////////////////////////////////////////////////
// read port
reg [7:0] rdMux;

// halves follow the justify bit when read, not when loaded; unmapped reads zero
always @* begin
	case (regAddr)
	`ADC_IDX_CTRL0: rdMux = {2'h0, analogChannelSelect, goFlag, converterOn};
	`ADC_IDX_CTRL1: rdMux = {2'h0, cfgRef, pinAnalogConfig};
	`ADC_IDX_CTRL2: rdMux = {resultJustify, 1'b0, acquisitionTimeSelect,
		conversionClockSelect};
	`ADC_IDX_RESHI: rdMux = resultJustify ? {6'h00, result[9:8]} : result[9:2];
	`ADC_IDX_RESLO: rdMux = resultJustify ? result[7:0] : {result[1:0], 6'h00};
	`ADC_IDX_STAT: rdMux = {7'h00, conversionDoneFlag};
	default: rdMux = 8'h00;
	endcase
end

// read data stand one cycle, then fall back to zero
always @(posedge clk) begin
	if (!rst_n) begin
		regRdData <= 8'h00;
	end else if (regRd) begin
		regRdData <= rdMux;
	end else begin
		regRdData <= 8'h00;
	end
end

endmodule

// [adc_defs.vh]
// constants for the converter control block
`ifndef ADC_DEFS_VH
`define ADC_DEFS_VH
`define ADC_IDX_CTRL0 3'h0
`define ADC_IDX_CTRL1 3'h1
`define ADC_IDX_CTRL2 3'h2
`define ADC_IDX_RESHI 3'h3
`define ADC_IDX_RESLO 3'h4
`define ADC_IDX_STAT 3'h5
`define ADC_RST_CTRL0 6'h00
`define ADC_RST_CFG 3'h0
`define ADC_RST_CTRL2 7'h00
`define ADC_PCFG_FUSE1 3'h0
`define ADC_PCFG_FUSE0 3'h7
`define ADC_CH_LAST 4'hc
`define ADC_CH_SMALL_LO 4'h5
`define ADC_CH_SMALL_HI 4'h7
`define ADC_PCFG_ALLA 4'h2
`define ADC_NUM_IN 13
`define ADC_CONV_TADS 4'hb
`define ADC_SAR_BITS 4'ha
`define ADC_TRIAL_MID 10'h200
`define ADC_TCY_CLKS 7'h04
`define ADC_RC_CLKS 7'h28
`define ADC_DIV2 7'h02
`define ADC_DIV4 7'h04
`define ADC_DIV8 7'h08
`define ADC_DIV16 7'h10
`define ADC_DIV32 7'h20
`define ADC_DIV64 7'h40
`define ADC_ACQ0 5'h00
`define ADC_ACQ1 5'h02
`define ADC_ACQ2 5'h04
`define ADC_ACQ3 5'h06
`define ADC_ACQ4 5'h08
`define ADC_ACQ5 5'h0c
`define ADC_ACQ6 5'h10
`define ADC_ACQ7 5'h14
`endif

// [tb_adc_control_registers.sv]
// self-checking bench for the converter control block
module tb_adc_control_registers;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, compIn, channelValid, sampleEn;
	logic portAnalogDefaultFuse = 1'b1, smallPackage = 1'b0, conversionDoneFlag;
	logic negReferenceSelect, posReferenceSelect;
	logic [2:0] regAddr = 3'h0;
	logic [7:0] regWrData = 8'h00, regRdData;
	logic [3:0] analogChannelSelect;
	logic [9:0] trialCode;
	logic [12:0] analogPinMask;
	int fails = 0, total_checks = 0, cyc = 0;
	always #50 clk = ~clk;
	adc_control_registers adc_control_registers_inst (.clk, .rst_n, .regAddr, .regWrData, .regWr,
		.regRd, .regRdData, .compIn, .portAnalogDefaultFuse, .smallPackage, .analogChannelSelect,
		.channelValid, .sampleEn, .trialCode, .negReferenceSelect, .posReferenceSelect,
		.analogPinMask, .conversionDoneFlag);
	acr_analog_model acr_analog_model_inst (.clk, .analogChannelSelect, .channelValid, .trialCode,
		.compIn);
	task automatic summarize;
		if (fails == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			summarize();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		chk(regRdData, e);
	endtask
	task automatic t_regs;
		rdchk(3'h0, 8'h00);
		rdchk(3'h1, 8'h00);
		chk(analogPinMask, 13'h1fff);
		wr(3'h0, 8'hfe);
		rdchk(3'h0, 8'h3c);
		wr(3'h1, 8'hff);
		rdchk(3'h1, 8'h3f);
		chk({negReferenceSelect, posReferenceSelect, analogPinMask}, 15'h6000);
		wr(3'h1, 8'h05);
		wr(3'h7, 8'hff);
		rdchk(3'h6, 8'h00);
		chk(analogPinMask, 13'h03ff);
		wr(3'h1, 8'h00);
	endtask
	task automatic t_convert;
		int tads[8] = '{2, 8, 32, 40, 4, 16, 64, 40};
		int acqs[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
		int n;
		logic [3:0] ch;
		logic [9:0] v;
		for (int i = 0; i < 8; i++) begin
			ch = 4'(i * 2);
			v = {ch, 6'h2d};
			wr(3'h2, {i[0], 1'b0, i[2:0], i[2:0]});
			wr(3'h5, 8'h00);
			wr(3'h0, {2'h0, ch, 2'h1});
			wr(3'h0, {2'h0, ch, 2'h3});
			n = 0;
			while (conversionDoneFlag !== 1'b1 && n < 3000) begin
				@(posedge clk);
				#1;
				n++;
			end
			chk(13'(n), 13'((i % 4 == 3 ? 4 : 0) + (acqs[i] + 11) * tads[i]));
			rdchk(3'h0, {2'h0, ch, 2'h1});
			chk(channelValid, ch <= 4'hc);
			if (ch <= 4'hc) begin
				rdchk(3'h3, i[0] ? {6'h00, v[9:8]} : v[9:2]);
				rdchk(3'h4, i[0] ? v[7:0] : {v[1:0], 6'h00});
			end
		end
	endtask
	task automatic t_abort_reset;
		wr(3'h0, 8'h00);
		#1;
		chk(sampleEn, 1'b0);
		wr(3'h2, 8'h06);
		wr(3'h5, 8'h00);
		wr(3'h0, 8'h01);
		wr(3'h0, 8'h03);
		rdchk(3'h0, 8'h03);
		wr(3'h0, 8'h00);
		repeat (60) @(posedge clk);
		#1;
		chk(conversionDoneFlag, 1'b0);
		wr(3'h0, 8'h01);
		wr(3'h0, 8'h03);
		smallPackage <= 1'b1;
		portAnalogDefaultFuse <= 1'b0;
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rdchk(3'h0, 8'h00);
		rdchk(3'h1, 8'h07);
		chk(analogPinMask, 13'h00ff);
		wr(3'h0, 8'h15);
		repeat (3) @(posedge clk);
		#1;
		chk(channelValid, 1'b0);
		wr(3'h0, 8'h11);
		repeat (3) @(posedge clk);
		#1;
		chk(channelValid, 1'b1);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_convert();
		t_abort_reset();
		summarize();
	end
endmodule
